/* ipl_consts.svh */
/*
 * Constants of the interrupt priority level block: register offsets,
 * field positions, reset values and level codes.
 * Assumes inclusion by bare name from the design files.
 */
// Function
// - Three-bit CPU priority level, 000 lowest
// - Enable set: CPU ranked at held level
// - Auto set on: hardware updates, writes ignored
// - Four 3-bit level fields per register
// - Levels rank all sources except non-maskable
// - Field code 000 lowest, 111 highest
// - Any written 000 to 111 is stored
// - Bits 15,11,7,3 reserved: read zero
// - Enable clear: CPU always lowest priority
// - Auto set copies CPU interrupt mask
// - Three-bit transfer controller level, compared
`ifndef IPL_CONSTS_SVH
`define IPL_CONSTS_SVH

`define IPL_ADDR_W          8
`define IPL_OFF_CPU_CTRL    8'h00
`define IPL_OFF_LEVEL_BASE  8'h04
`define IPL_OFF_LEVEL_LAST  8'h24
`define IPL_NUM_LEVEL_REGS  9
`define IPL_NUM_SRC         36
`define IPL_FIELDS_PER_REG  4
`define IPL_FIELD_W         3
`define IPL_FIELD_STRIDE    4

`define IPL_CTRL_PCE_BIT    7
`define IPL_CTRL_XFER_HI    6
`define IPL_CTRL_XFER_LO    4
`define IPL_CTRL_AUTO_BIT   3
`define IPL_CTRL_CPU_HI     2
`define IPL_CTRL_CPU_LO     0
`define IPL_CTRL_RESET      8'h00

`define IPL_LEVEL_RESET     16'h7777
`define IPL_LEVEL_FIELD_RST 3'h7
`define IPL_LEVEL_LOWEST    3'h0
`define IPL_LEVEL_HIGHEST   3'h7

`endif

/* ipl_pkg.sv */
/*
 * Types shared by the interrupt priority level block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ipl_pkg;
    typedef logic [2:0] ipl_level_t;
    typedef enum logic { IPL_MASK_SINGLE_BIT, IPL_MASK_THREE_BIT } ipl_mask_mode_t;
endpackage

/* ipl_level_reg.sv */
/*
 * One interrupt level register: four 3-bit level fields.
 * Assumes a write strobe already qualified by the bus slave.
 */
`timescale 1ns/1ps
`include "ipl_consts.svh"
module ipl_level_reg (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              wrEn,
    input  wire logic [1:0]        byteEn,
    input  wire logic [15:0]       wrData,
    output ipl_pkg::ipl_level_t    fieldLevel [4],
    output logic [15:0]            readValue
);
    always_ff @(posedge clk) begin
        for (int k = 0; k < `IPL_FIELDS_PER_REG; k++) begin
            if (!rst_n) begin
                fieldLevel[k] <= `IPL_LEVEL_FIELD_RST;
            end else if (wrEn && byteEn[k/2]) begin
                // Every code is legal, so no filtering here
                fieldLevel[k] <= wrData[k*`IPL_FIELD_STRIDE +: `IPL_FIELD_W];
            end
        end
    end

    // Reserved bits never stored, always zero
    assign readValue = {1'b0, fieldLevel[3], 1'b0, fieldLevel[2],
                        1'b0, fieldLevel[1], 1'b0, fieldLevel[0]};
endmodule // ipl_level_reg

/* ipl_cpu_prio_ctrl.sv */
/*
 * CPU priority control register with automatic level update.
 * Assumes the mask inputs come from CPU logic on the same clock.
 */
`timescale 1ns/1ps
`include "ipl_consts.svh"
module ipl_cpu_prio_ctrl (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    wrEn,
    input  wire logic [7:0]              wrData,
    input  wire ipl_pkg::ipl_mask_mode_t maskMode,
    input  wire logic                    maskBit,
    input  wire ipl_pkg::ipl_level_t     maskLevel,
    output logic                         prioCtrlEnable,
    output ipl_pkg::ipl_level_t          xferLevel,
    output logic                         autoSetEnable,
    output ipl_pkg::ipl_level_t          cpuLevel,
    output logic [7:0]                   readValue
);
    ipl_pkg::ipl_level_t maskValue;

    // Named so its fields can be selected
    localparam logic [7:0] CTRL_RST = `IPL_CTRL_RESET;

    // A set single mask bit blocks everything, so it maps to the top level
    always_comb begin
        case (maskMode)
            ipl_pkg::IPL_MASK_SINGLE_BIT:
                maskValue = maskBit ? `IPL_LEVEL_HIGHEST : `IPL_LEVEL_LOWEST;
            ipl_pkg::IPL_MASK_THREE_BIT: maskValue = maskLevel;
            default: maskValue = maskLevel;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prioCtrlEnable <= CTRL_RST[`IPL_CTRL_PCE_BIT];
            xferLevel      <= CTRL_RST[`IPL_CTRL_XFER_HI:`IPL_CTRL_XFER_LO];
            autoSetEnable  <= CTRL_RST[`IPL_CTRL_AUTO_BIT];
        end else if (wrEn) begin
            prioCtrlEnable <= wrData[`IPL_CTRL_PCE_BIT];
            xferLevel      <= wrData[`IPL_CTRL_XFER_HI:`IPL_CTRL_XFER_LO];
            autoSetEnable  <= wrData[`IPL_CTRL_AUTO_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpuLevel <= CTRL_RST[`IPL_CTRL_CPU_HI:`IPL_CTRL_CPU_LO];
        end else if (autoSetEnable) begin
            cpuLevel <= maskValue;
        end else if (wrEn) begin
            cpuLevel <= wrData[`IPL_CTRL_CPU_HI:`IPL_CTRL_CPU_LO];
        end
    end

    assign readValue = {prioCtrlEnable, xferLevel, autoSetEnable, cpuLevel};
endmodule // ipl_cpu_prio_ctrl

/* ipl_priority_levels.sv */
/*
 * Interrupt priority level block: APB register slave, CPU priority
 * control, level registers and highest-level pending source selection.
 * Assumes request and mask inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "ipl_consts.svh"
module ipl_priority_levels (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic [7:0]              paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [35:0]             intReq,
    input  wire logic                    nmiReq,
    input  wire ipl_pkg::ipl_mask_mode_t maskMode,
    input  wire logic                    maskBit,
    input  wire ipl_pkg::ipl_level_t     maskLevel,
    output ipl_pkg::ipl_level_t          cpuRankLevel,
    output ipl_pkg::ipl_level_t          xferRankLevel,
    output logic                         cpuOverXfer,
    output logic                         pendValid,
    output logic [5:0]                   pendId,
    output ipl_pkg::ipl_level_t          pendLevel,
    output logic                         nmiPending
);
    logic                prioCtrlEnable;
    logic                autoSetEnable;
    ipl_pkg::ipl_level_t xferLevel;
    ipl_pkg::ipl_level_t cpuLevel;
    logic [7:0]          ctrlRead;
    logic [15:0]         levelRead [`IPL_NUM_LEVEL_REGS];
    ipl_pkg::ipl_level_t srcLevel [`IPL_NUM_SRC];
    logic                accessPhase;
    logic                accessDone;
    logic                ctrlHit;
    logic                levelHit;
    logic [3:0]          levelIdx;
    logic                ready_q;
    logic                err_q;
    logic [31:0]         rdata_q;
    logic [31:0]         rdata_d;

    // Level registers sit one word apart after the control register
    function automatic logic [3:0] levelIndexOf(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - `IPL_OFF_LEVEL_BASE;
        return rel[5:2];
    endfunction

    function automatic logic isLevelAddr(input logic [7:0] addr);
        return addr[1:0] == 2'h0 && addr >= `IPL_OFF_LEVEL_BASE &&
               addr <= `IPL_OFF_LEVEL_LAST;
    endfunction

    assign accessPhase = psel && penable;
    assign accessDone  = accessPhase && ready_q;
    assign ctrlHit     = paddr == `IPL_OFF_CPU_CTRL;
    assign levelHit    = isLevelAddr(paddr);
    assign levelIdx    = levelIndexOf(paddr);

    // One wait state keeps pready and prdata straight from flip-flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else if (accessPhase && !ready_q) begin
            ready_q <= 1'b1;
            err_q   <= !(ctrlHit || levelHit);
        end else begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (ctrlHit) begin
            rdata_d = {24'h00_0000, ctrlRead};
        end else if (levelHit) begin
            rdata_d = {16'h0000, levelRead[levelIdx]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (accessPhase && !ready_q && !pwrite) begin
            rdata_q <= rdata_d;
        end else begin
            // Read data stands only in the ready cycle
            rdata_q <= 32'h0000_0000;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = ready_q;
    assign pslverr = err_q;

    ipl_cpu_prio_ctrl u_ctrl (
        .clk            (clk),
        .rst_n          (rst_n),
        .wrEn           (accessDone && pwrite && ctrlHit && pstrb[0]),
        .wrData         (pwdata[7:0]),
        .maskMode       (maskMode),
        .maskBit        (maskBit),
        .maskLevel      (maskLevel),
        .prioCtrlEnable (prioCtrlEnable),
        .xferLevel      (xferLevel),
        .autoSetEnable  (autoSetEnable),
        .cpuLevel       (cpuLevel),
        .readValue      (ctrlRead)
    );

    for (genvar r = 0; r < `IPL_NUM_LEVEL_REGS; r++) begin : g_level
        ipl_pkg::ipl_level_t fields [4];
        ipl_level_reg u_reg (
            .clk        (clk),
            .rst_n      (rst_n),
            .wrEn       (accessDone && pwrite && levelHit &&
                         levelIdx == 4'(r)),
            .byteEn     (pstrb[1:0]),
            .wrData     (pwdata[15:0]),
            .fieldLevel (fields),
            .readValue  (levelRead[r])
        );
        for (genvar k = 0; k < `IPL_FIELDS_PER_REG; k++) begin : g_field
            assign srcLevel[r*`IPL_FIELDS_PER_REG + k] = fields[k];
        end
    end

    // Disabled control leaves the CPU at the bottom whatever it holds
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpuRankLevel  <= `IPL_LEVEL_LOWEST;
            xferRankLevel <= `IPL_LEVEL_LOWEST;
            cpuOverXfer   <= 1'b0;
        end else begin
            cpuRankLevel  <= prioCtrlEnable ? cpuLevel
                                            : `IPL_LEVEL_LOWEST;
            xferRankLevel <= xferLevel;
            cpuOverXfer   <= prioCtrlEnable && cpuLevel > xferLevel;
        end
    end

    // Ties go to the lower source number
    ipl_pkg::ipl_level_t bestLevel;
    logic [5:0]          bestId;
    logic                bestFound;

    always_comb begin
        bestLevel = `IPL_LEVEL_LOWEST;
        bestId    = 6'h00;
        bestFound = 1'b0;
        for (int i = 0; i < `IPL_NUM_SRC; i++) begin
            if (intReq[i] && (!bestFound || srcLevel[i] > bestLevel)) begin
                bestLevel = srcLevel[i];
                bestId    = 6'(i);
                bestFound = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pendValid <= 1'b0;
            pendId    <= 6'h00;
            pendLevel <= `IPL_LEVEL_LOWEST;
        end else begin
            pendValid <= bestFound;
            pendId    <= bestId;
            pendLevel <= bestLevel;
        end
    end

    // Non-maskable request bypasses all level fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nmiPending <= 1'b0;
        end else begin
            nmiPending <= nmiReq;
        end
    end
endmodule // ipl_priority_levels

/* ipl_prio_sva.sv */
/* Port checker for the priority level block.
   Assumes the bind below and one clock domain. */
`timescale 1ns/1ps
module ipl_prio_sva (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic [7:0]          paddr,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [35:0]         intReq,
    input wire logic                nmiReq,
    input wire ipl_pkg::ipl_level_t cpuRankLevel,
    input wire ipl_pkg::ipl_level_t xferRankLevel,
    input wire logic                cpuOverXfer,
    input wire logic                pendValid,
    input wire logic [5:0]          pendId,
    input wire logic                nmiPending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wait_s; psel && penable && !pready; endsequence
    sequence done_s; ##1 pready ##1 !pready; endsequence
    a_ready_one_wait: assert property (
        wait_s |-> done_s) else $error("ready not after one wait");
    a_rsvd_zero: assert property (
        pready && !pwrite && !pslverr && paddr != 8'h00
        |-> (prdata & 32'hffff8888) == 32'h0) else $error("reserved set");
    a_err_unmapped: assert property (
        psel && penable && pready && (paddr > 8'h24 || paddr[1:0] != 2'h0)
        |-> pslverr && prdata == 32'h0) else $error("bad address taken");
    a_err_with_ready: assert property (
        pslverr |-> pready) else $error("error without ready");
    a_idle_data: assert property (
        !pready |-> prdata == 32'h0) else $error("read data outside ready");
    a_cpu_over: assert property (
        cpuOverXfer |-> cpuRankLevel > xferRankLevel)
        else $error("cpu ranked over wrongly");
    a_pend_follow: assert property (
        (|intReq) |=> pendValid) else $error("request not pending");
    a_nmi_apart: assert property (
        nmiReq && !(|intReq) |=> !pendValid && nmiPending)
        else $error("nmi mixed with levels");
    a_pend_range: assert property (
        pendValid |-> pendId < 6'h24) else $error("source out of range");
endmodule // ipl_prio_sva
bind ipl_priority_levels ipl_prio_sva ipl_prio_sva_inst (.clk, .rst_n,
    .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .intReq,
    .nmiReq, .cpuRankLevel, .xferRankLevel, .cpuOverXfer, .pendValid,
    .pendId, .nmiPending);

/* ipl_cpu_model.sv */
/* CPU core model: presents its interrupt mask.
   Assumes the bench chooses mode and level. */
`timescale 1ns/1ps
module ipl_cpu_model (
    input wire logic                clk,
    input wire logic                wantThree,
    input wire logic [2:0]          wantLevel,
    output ipl_pkg::ipl_mask_mode_t maskMode,
    output logic                    maskBit,
    output ipl_pkg::ipl_level_t     maskLevel
);
    // Mask moves only on edges, as the core's would
    always_ff @(posedge clk) begin
        maskMode <= ipl_pkg::ipl_mask_mode_t'(wantThree);
        maskBit <= wantLevel != 3'h0;
        maskLevel <= wantLevel;
    end
endmodule // ipl_cpu_model

/* ipl_tb.sv */
/* Self-checking bench for the priority level block.
   Assumes the checker binds from its own file. */
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic nmiReq = 0, wantThree = 0, err, maskBit;
    logic cpuOverXfer, pendValid, nmiPending, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [3:0] pstrb = 4'h0;
    logic [35:0] intReq = 36'h0;
    logic [2:0] wantLevel = 3'h0;
    logic [5:0] pendId;
    ipl_pkg::ipl_mask_mode_t maskMode;
    ipl_pkg::ipl_level_t maskLevel, cpuRankLevel, xferRankLevel, pendLevel;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    ipl_priority_levels ipl_priority_levels_inst (.clk(clk), .rst_n(rst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .intReq(intReq), .nmiReq(nmiReq),
        .maskMode(maskMode), .maskBit(maskBit), .maskLevel(maskLevel),
        .cpuRankLevel(cpuRankLevel), .xferRankLevel(xferRankLevel),
        .cpuOverXfer(cpuOverXfer), .pendValid(pendValid), .pendId(pendId),
        .pendLevel(pendLevel), .nmiPending(nmiPending));
    ipl_cpu_model ipl_cpu_model_inst (.clk(clk), .wantThree(wantThree),
        .wantLevel(wantLevel), .maskMode(maskMode), .maskBit(maskBit),
        .maskLevel(maskLevel));
    always #12.5 clk = ~clk;
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d, 4'hf);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x, logic e);
        apb(0, a, 32'h0, 4'h0);
        chk(rd, x);
        chk({31'h0, err}, {31'h0, e});
    endtask
    task automatic t_reset();
        rdc(8'h00, 32'h0, 0);
        for (int i = 0; i < 9; i++) rdc(8'(4 + 4 * i), 32'h7777, 0);
        chk(32'(cpuRankLevel), 32'h0);
    endtask
    task automatic t_fields();
        for (int k = 0; k < 8; k++) begin
            wr(8'h08, 32'hffff8888 | 32'(k) * 32'h1111);
            rdc(8'h08, 32'(k) * 32'h1111, 0);
        end
        apb(1, 8'h08, 32'h0, 4'h2);
        rdc(8'h08, 32'h0077, 0);
    endtask
    task automatic t_pend();
        for (int i = 0; i < 9; i++) wr(8'(4 + 4 * i), 32'h0);
        wr(8'h0c, 32'h5000);
        wr(8'h04, 32'h0300);
        intReq <= 36'h804;
        repeat (2) @(posedge clk);
        chk(32'(pendId), 32'hb);
        chk(32'(pendLevel), 32'h5);
        wr(8'h24, 32'h7000);
        intReq <= 36'h800000804;
        repeat (2) @(posedge clk);
        chk(32'(pendId), 32'h23);
        intReq <= 36'h0;
        nmiReq <= 1;
        repeat (2) @(posedge clk);
        chk({31'h0, pendValid}, 32'h0);
        chk({31'h0, nmiPending}, 32'h1);
        nmiReq <= 0;
    endtask
    task automatic t_cpu();
        for (int k = 0; k < 8; k++) begin
            wr(8'h00, 32'h80 | 32'(k));
            rdc(8'h00, 32'h80 | 32'(k), 0);
            chk(32'(cpuRankLevel), 32'(k));
        end
        wr(8'h00, 32'hb5);
        repeat (2) @(posedge clk);
        chk(32'(xferRankLevel), 32'h3);
        chk({31'h0, cpuOverXfer}, 32'h1);
        wr(8'h00, 32'h35);
        repeat (2) @(posedge clk);
        chk(32'(cpuRankLevel), 32'h0);
        chk({31'h0, cpuOverXfer}, 32'h0);
    endtask
    task automatic t_auto();
        wantThree <= 1;
        wantLevel <= 3'h4;
        wr(8'h00, 32'h8a);
        rdc(8'h00, 32'h8c, 0);
        wr(8'h00, 32'h89);
        rdc(8'h00, 32'h8c, 0);
        wantThree <= 0;
        wantLevel <= 3'h1;
        repeat (3) @(posedge clk);
        rdc(8'h00, 32'h8f, 0);
        wantLevel <= 3'h0;
        repeat (3) @(posedge clk);
        rdc(8'h00, 32'h88, 0);
        rdc(8'h40, 32'h0, 1);
        rdc(8'h06, 32'h0, 1);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_reset();
        t_fields();
        t_pend();
        t_cpu();
        t_auto();
        final_report();
    end
endmodule // testbench
